//--- hdl/plcs_defines.svh
// Constants of the scan-cycle controller: offsets, fields, resets, timing
// Function
// - Run program step 0 to end, repeat
// - Evaluate rung left to right, top down
// - End: update timers, run self-diagnostics
// - Batch-sample inputs into image before scan
// - Coils write image; image output after end
// - Contacts read input and output images
// - Input reaches outputs within one to two scans
// - Time end-to-end interval in 10 ms units
// - Hold minimum, present and maximum scan time
// - Scan time accurate to one count
// - Stop: keep output image, force outputs off
// - Reset clears bit and word devices
// - Refresh continues while running and stopped
`ifndef PLCS_DEFINES_SVH
`define PLCS_DEFINES_SVH
// Register byte offsets
`define PLCS_ADR_CTRL      13'h0000
`define PLCS_ADR_STATUS    13'h0004
`define PLCS_ADR_SCAN_MIN  13'h0008
`define PLCS_ADR_SCAN_PRES 13'h000C
`define PLCS_ADR_SCAN_MAX  13'h0010
`define PLCS_ADR_X_IMG     13'h0014
`define PLCS_ADR_Y_IMG     13'h0018
`define PLCS_ADR_PINS      13'h001C
`define PLCS_ADR_TMR_BASE  13'h0800
`define PLCS_ADR_PROG_BASE 13'h1000
// Control and status fields
`define PLCS_CTRL_RUN      0
`define PLCS_CTRL_DIAG_CLR 1
`define PLCS_STAT_RUNNING  0
`define PLCS_STAT_DIAG     1
`define PLCS_STAT_PC_LSB   16
// Reset values
`define PLCS_CTRL_RST      1'b0
`define PLCS_SCAN_RST      16'h0000
// Sizes of the device ranges
`define PLCS_NX            12
`define PLCS_NY            7
`define PLCS_NT            16
`define PLCS_PROG_DEPTH    1024
// Timing: 10 ms unit at a 50 ns clock
`define PLCS_SCAN_UNIT_NS  10000000
`define PLCS_CLK_NS        50
`define PLCS_TICK_CYC      (`PLCS_SCAN_UNIT_NS / `PLCS_CLK_NS)
`endif

//--- hdl/plcs_pkg.sv
// Types shared by the scan-cycle controller modules
package plcs_pkg;
  typedef enum logic [1:0] {S_INIT, S_REFRESH, S_EXEC, S_END} plcs_state_type;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_LD  = 4'h1, OP_LDI = 4'h2, OP_AND = 4'h3, OP_ANI = 4'h4,
    OP_OR  = 4'h5, OP_ORI = 4'h6, OP_OUT = 4'h7, OP_END = 4'hF
  } plcs_op_type;
  typedef enum logic [1:0] {DEV_X, DEV_Y, DEV_T, DEV_NONE} plcs_dev_type;
  typedef struct packed {
    plcs_op_type  op;
    plcs_dev_type dev;
    logic [3:0]   rsvd;
    logic [5:0]   idx;
  } plcs_instr_type;
  typedef struct packed {
    logic [15:0] min;
    logic [15:0] present;
    logic [15:0] max;
  } plcs_scan_type;
  typedef struct packed {
    logic [11:0] ff1;
    logic [11:0] ff2;
    logic [11:0] ff3;
    logic [11:0] q;
  } plcs_sync_type;
  typedef struct packed {
    logic [17:0]   pre;
    logic [15:0]   ticks;
    logic          valid;
    plcs_scan_type scan;
  } plcs_timer_type;
  typedef struct packed {
    plcs_state_type st;
    logic           run_req;
    logic           running;
    logic           diag_err;
    logic [9:0]     pc;
    logic           acc;
    logic [11:0]    x_img;
    logic [6:0]     y_img;
    logic [6:0]     pins;
    logic [15:0]    t_coil;
    logic [3:0]     t_idx;
    logic           ack;
    logic [31:0]    rdat;
  } plcs_ctrl_type;
endpackage

//--- hdl/plcs_in_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module plcs_in_sync (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Pins and filtered result
  input  wire logic [11:0] pin_in,
  output logic      [11:0] q
);
  plcs_pkg::plcs_sync_type s_r;
  plcs_pkg::plcs_sync_type s_nxt;

  // Shift chain; result follows once stages two and three agree
  always_comb begin
    s_nxt     = s_r;
    s_nxt.ff1 = pin_in;
    s_nxt.ff2 = s_r.ff1;
    s_nxt.ff3 = s_r.ff2;
    for (int i = 0; i < 12; i++) begin
      if (s_r.ff2[i] == s_r.ff3[i]) begin
        s_nxt.q[i] = s_r.ff3[i];
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.q;
endmodule

//--- hdl/plcs_scan_timer.sv
// Scan time measurement in 10 ms units: minimum, present, maximum
`timescale 1ns/1ns
`include "plcs_defines.svh"
module plcs_scan_timer #(
  parameter int TICK_CYC = `PLCS_TICK_CYC
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    ce,
  // Scan events
  input  wire logic                    end_p,
  input  wire logic                    restart,
  // Results
  output plcs_pkg::plcs_scan_type      scan,
  output logic                         valid
);
  plcs_pkg::plcs_timer_type s_r;
  plcs_pkg::plcs_timer_type s_nxt;

  // Free prescaler counts units; interval sampled end to end
  always_comb begin
    s_nxt = s_r;
    if (s_r.pre == 18'(TICK_CYC - 1)) begin
      s_nxt.pre = '0;
      if (s_r.ticks != 16'hFFFF) begin
        s_nxt.ticks = s_r.ticks + 16'h0001;
      end
    end else begin
      s_nxt.pre = s_r.pre + 18'h0_0001;
    end
    if (restart) begin
      s_nxt.ticks = '0;
    end else if (end_p) begin
      s_nxt.ticks        = '0;
      s_nxt.scan.present = s_r.ticks;
      s_nxt.valid        = 1'b1;
      if (!s_r.valid || s_r.ticks < s_r.scan.min) begin
        s_nxt.scan.min = s_r.ticks;
      end
      if (!s_r.valid || s_r.ticks > s_r.scan.max) begin
        s_nxt.scan.max = s_r.ticks;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign scan  = s_r.scan;
  assign valid = s_r.valid;

  // Ordering of the three values once seeded
  min_max_order_a: assert property (@(posedge clk) disable iff (rst)
    s_r.valid |-> (s_r.scan.min <= s_r.scan.present && s_r.scan.present <= s_r.scan.max))
    else $error("scan min/present/max out of order");
  // First measurement seeds both extremes
  first_seed_a: assert property (@(posedge clk) disable iff (rst)
    (ce && end_p && !restart && !s_r.valid) |=>
      (s_r.scan.min == $past(s_r.ticks) && s_r.scan.max == $past(s_r.ticks)))
    else $error("first scan did not seed min and max");
  // Present value moves only on an end event
  present_hold_a: assert property (@(posedge clk) disable iff (rst)
    $changed(s_r.scan.present) |-> $past(end_p && ce))
    else $error("present scan time changed without end");
endmodule

//--- hdl/plcs_ctrl.sv
// Scan-cycle controller: program engine, I/O refresh, registers
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/1ns
`include "plcs_defines.svh"
module plcs_ctrl #(
  parameter int TICK_CYC = `PLCS_TICK_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [12:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Control terminals
  input  wire logic [11:0] in_pins,
  output logic      [6:0]  out_pins
);
  ////////////////////////////////////////////////////////////////////////////
  // Storage
  plcs_pkg::plcs_ctrl_type   s_r;
  plcs_pkg::plcs_ctrl_type   s_nxt;
  logic [15:0]               prog_mem [`PLCS_PROG_DEPTH];
  logic [15:0]               tmr_pv   [`PLCS_NT];
  logic [11:0]               x_sync;
  plcs_pkg::plcs_scan_type   scan;
  logic                      scan_valid;
  plcs_pkg::plcs_instr_type  instr;
  logic                      end_p;
  logic                      restart;
  logic                      tmr_we;
  logic [15:0]               tmr_wdat;
  logic                      acc_bus;
  logic                      wr_hit;
  logic                      operand;
  logic [16:0]               tmr_sum;

  // Operand fetch from the images
  function automatic logic dev_bit(input plcs_pkg::plcs_dev_type dev,
                                   input logic [5:0] idx,
                                   input logic [11:0] x,
                                   input logic [6:0] y,
                                   input logic [15:0] tpv_nz);
    logic [11:0] xs;
    logic [6:0]  ys;
    logic [15:0] ts;
    xs = x >> idx;
    ys = y >> idx;
    ts = tpv_nz >> idx;
    case (dev)
      plcs_pkg::DEV_X: dev_bit = xs[0];
      plcs_pkg::DEV_Y: dev_bit = ys[0];
      plcs_pkg::DEV_T: dev_bit = ts[0];
      default:         dev_bit = 1'b0;
    endcase
  endfunction

  // Timers that have accumulated time
  logic [15:0] tpv_nz;
  always_comb begin
    for (int i = 0; i < `PLCS_NT; i++) begin
      tpv_nz[i] = (tmr_pv[i] != 16'h0000);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Submodules
  plcs_in_sync u_sync (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .pin_in (in_pins),
    .q      (x_sync)
  );

  plcs_scan_timer #(.TICK_CYC(TICK_CYC)) u_scan (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .end_p   (end_p),
    .restart (restart),
    .scan    (scan),
    .valid   (scan_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode
  assign instr   = plcs_pkg::plcs_instr_type'(prog_mem[s_r.pc]);
  assign operand = dev_bit(instr.dev, instr.idx, s_r.x_img, s_r.y_img, tpv_nz);
  assign end_p   = (s_r.st == plcs_pkg::S_EXEC) && s_r.running && s_r.run_req &&
                   (instr.op == plcs_pkg::OP_END || s_r.pc == 10'h3FF);
  assign restart = (s_r.st == plcs_pkg::S_REFRESH) && !s_r.running && s_r.run_req;
  assign tmr_sum = {1'b0, tmr_pv[s_r.t_idx]} + {1'b0, scan.present};
  assign acc_bus = wb_cyc_i && wb_stb_i && !s_r.ack;
  assign wr_hit  = acc_bus && wb_we_i;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer, images and bus slave
  always_comb begin
    s_nxt    = s_r;
    tmr_we   = 1'b0;
    tmr_wdat = 16'h0000;
    case (s_r.st)
      plcs_pkg::S_INIT: begin
        // Clear the timer present values one timer per cycle; bit devices are cleared by reset
        tmr_we      = 1'b1;
        s_nxt.t_idx = s_r.t_idx + 4'h1;
        if (s_r.t_idx == 4'hF) begin
          s_nxt.st = plcs_pkg::S_REFRESH;
        end
      end
      plcs_pkg::S_REFRESH: begin
        // Output refresh and input refresh in the same cycle, in either run state
        s_nxt.pins  = s_r.running ? s_r.y_img : 7'h00;
        s_nxt.x_img = x_sync;
        if (s_r.run_req) begin
          s_nxt.running = 1'b1;
          s_nxt.st      = plcs_pkg::S_EXEC;
          s_nxt.pc      = '0;
          s_nxt.acc     = 1'b0;
        end
      end
      plcs_pkg::S_EXEC: begin
        // One instruction per cycle; acc carries the rung left to right
        s_nxt.pc = s_r.pc + 10'h001;
        case (instr.op)
          plcs_pkg::OP_LD:  s_nxt.acc = operand;
          plcs_pkg::OP_LDI: s_nxt.acc = !operand;
          plcs_pkg::OP_AND: s_nxt.acc = s_r.acc & operand;
          plcs_pkg::OP_ANI: s_nxt.acc = s_r.acc & !operand;
          plcs_pkg::OP_OR:  s_nxt.acc = s_r.acc | operand;
          plcs_pkg::OP_ORI: s_nxt.acc = s_r.acc | !operand;
          plcs_pkg::OP_OUT: begin
            // Coils land in the image only, never on the pins
            if (instr.dev == plcs_pkg::DEV_Y && instr.idx < 6'd7) begin
              s_nxt.y_img[instr.idx[2:0]] = s_r.acc;
            end
            if (instr.dev == plcs_pkg::DEV_T && instr.idx < 6'd16) begin
              s_nxt.t_coil[instr.idx[3:0]] = s_r.acc;
            end
          end
          default: begin
          end
        endcase
        if (end_p) begin
          // Running off the end of memory is a diagnostic fault
          if (instr.op != plcs_pkg::OP_END) begin
            s_nxt.diag_err = 1'b1;
          end
          s_nxt.st    = plcs_pkg::S_END;
          s_nxt.t_idx = '0;
        end
      end
      plcs_pkg::S_END: begin
        // Timer update walk, then self-check decides on running
        tmr_we      = 1'b1;
        tmr_wdat    = !s_r.t_coil[s_r.t_idx] ? 16'h0000 :
                      (tmr_sum[16] ? 16'hFFFF : tmr_sum[15:0]);
        s_nxt.t_idx = s_r.t_idx + 4'h1;
        if (s_r.t_idx == 4'hF) begin
          s_nxt.st = plcs_pkg::S_REFRESH;
          if (s_r.diag_err) begin
            s_nxt.run_req = 1'b0;
          end
        end
      end
      default: s_nxt.st = plcs_pkg::S_INIT;
    endcase
    // Stop entry keeps the image but turns every output off
    if (s_r.st != plcs_pkg::S_INIT && s_r.running && !s_nxt.run_req) begin
      s_nxt.running = 1'b0;
      s_nxt.pins    = 7'h00;
      s_nxt.st      = plcs_pkg::S_REFRESH;
    end
    // Bus slave: ack one cycle after the strobe, then drop
    s_nxt.ack  = acc_bus;
    s_nxt.rdat = 32'h0000_0000;
    if (acc_bus && !wb_we_i) begin
      case (wb_adr_i)
        `PLCS_ADR_CTRL:      s_nxt.rdat[`PLCS_CTRL_RUN] = s_r.run_req;
        `PLCS_ADR_STATUS:    s_nxt.rdat = {6'h00, s_r.pc, 14'h0000,
                                           s_r.diag_err, s_r.running};
        `PLCS_ADR_SCAN_MIN:  s_nxt.rdat[15:0] = scan.min;
        `PLCS_ADR_SCAN_PRES: s_nxt.rdat[15:0] = scan.present;
        `PLCS_ADR_SCAN_MAX:  s_nxt.rdat[15:0] = scan.max;
        `PLCS_ADR_X_IMG:     s_nxt.rdat[11:0] = s_r.x_img;
        `PLCS_ADR_Y_IMG:     s_nxt.rdat[6:0]  = s_r.y_img;
        `PLCS_ADR_PINS:      s_nxt.rdat[6:0]  = s_r.pins;
        default: begin
          if (wb_adr_i[12:6] == 7'(`PLCS_ADR_TMR_BASE >> 6)) begin
            s_nxt.rdat[15:0] = tmr_pv[wb_adr_i[5:2]];
          end
        end
      endcase
    end
    if (wr_hit && wb_adr_i == `PLCS_ADR_CTRL && wb_sel_i[0]) begin
      s_nxt.run_req = wb_dat_i[`PLCS_CTRL_RUN];
      // A fault found in the same cycle wins over the clear
      if (wb_dat_i[`PLCS_CTRL_DIAG_CLR] && !(end_p && instr.op != plcs_pkg::OP_END)) begin
        s_nxt.diag_err = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // Program store, written over the bus, kept across reset
  always_ff @(posedge clk) begin
    if (ce && wr_hit && wb_adr_i[12] && (&wb_sel_i[1:0])) begin
      prog_mem[wb_adr_i[11:2]] <= wb_dat_i[15:0];
    end
  end

  // Timer present values: cleared at init, advanced at end
  always_ff @(posedge clk) begin
    if (ce && tmr_we) begin
      tmr_pv[s_r.t_idx] <= tmr_wdat;
    end
  end

  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.rdat;
  assign out_pins = s_r.pins;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  stopped_pins_off_a: assert property (!s_r.running |-> out_pins == 7'h00)
    else $error("outputs driven while stopped");
  pins_at_refresh_a: assert property (
    ($changed(out_pins) && s_r.running) |-> $past(s_r.st == plcs_pkg::S_REFRESH))
    else $error("outputs changed outside output refresh");
  pins_from_image_a: assert property (
    (ce && s_r.st == plcs_pkg::S_REFRESH && s_r.running && s_r.run_req) |=>
      out_pins == $past(s_r.y_img))
    else $error("outputs do not match output image");
  ximg_at_refresh_a: assert property (
    $changed(s_r.x_img) |-> $past(s_r.st == plcs_pkg::S_REFRESH))
    else $error("input image changed outside input refresh");
  scan_starts_zero_a: assert property (
    (ce && s_r.st == plcs_pkg::S_REFRESH && s_r.run_req) |=>
      (s_r.st == plcs_pkg::S_EXEC && s_r.pc == 10'h000 && s_r.acc == 1'b0))
    else $error("scan did not start at step zero");
  end_walk_len_a: assert property (
    (ce && end_p) ##1 ce [*8] ##1 ce [*8] |=> s_r.st == plcs_pkg::S_REFRESH)
    else $error("end processing not sixteen cycles");
  ycontact_reads_img_a: assert property (
    (ce && s_r.st == plcs_pkg::S_EXEC && s_r.running && s_r.run_req &&
     instr.op == plcs_pkg::OP_LD && instr.dev == plcs_pkg::DEV_Y && instr.idx < 6'd7) |=>
      s_r.acc == $past(s_r.y_img[instr.idx[2:0]]))
    else $error("output contact did not read the output image");
  init_clears_a: assert property (
    (s_r.st == plcs_pkg::S_INIT) |-> (s_r.y_img == 7'h00 && !s_r.running))
    else $error("devices not clear during init");

  // Bus answer is a one-cycle pulse, data only beside it
  ack_one_cycle_a: assert property ((ce && wb_ack_o) |=> !wb_ack_o)
    else $error("bus acknowledge held longer than one cycle");
  ack_after_req_a: assert property (
    (ce && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  rdat_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data present without acknowledge");
  // Running off memory without an end step raises the fault
  diag_on_overrun_a: assert property (
    (ce && end_p && instr.op != plcs_pkg::OP_END) |=> s_r.diag_err)
    else $error("missing end step did not raise the fault");
  // Timer update never wraps below the old present value
  timer_saturates_a: assert property (
    (ce && s_r.st == plcs_pkg::S_END && s_r.t_coil[s_r.t_idx]) |->
      tmr_wdat >= tmr_pv[s_r.t_idx])
    else $error("timer present value wrapped");
  // Stop entry outside execution leaves the output image alone
  stop_keeps_image_a: assert property (
    (ce && s_r.running && !s_nxt.run_req && s_r.st != plcs_pkg::S_INIT &&
     s_r.st != plcs_pkg::S_EXEC) |=> s_r.y_img == $past(s_r.y_img))
    else $error("stop entry altered the output image");
  // Input refresh keeps going while stopped
  refresh_stopped_a: assert property (
    (ce && s_r.st == plcs_pkg::S_REFRESH && !s_r.running) |=>
      s_r.x_img == $past(x_sync))
    else $error("input image not refreshed while stopped");
  // Clock enable low holds the terminals
  pins_frozen_ce_a: assert property (!ce |=> $stable(out_pins))
    else $error("outputs moved with clock enable low");

  scan_done_c: cover property (ce && end_p);
  restart_c: cover property (ce && restart);
  ce_hold_c: cover property (!ce ##1 !ce);
  stop_entry_c: cover property (s_r.running ##1 !s_r.running);
  diag_fault_c: cover property (!s_r.diag_err ##1 s_r.diag_err);
endmodule

//--- tb/plcs_term_model.sv
// Model of the inverter control input terminals driven toward the controller
`timescale 1ns/1ns
module plcs_term_model (
  // Clock
  input  wire logic        clk,
  // Levels wanted on the input terminals
  input  wire logic [11:0] want,
  // Terminal lines
  output logic      [11:0] in_pins,
  // Cycles since the last input change
  output int               since_chg
);
  ////////////////////////////////////////////////////////////////////////////
  // Apply the wanted levels and age the last change
  initial begin
    in_pins = 12'h000;
    since_chg = 0;
  end
  always @(posedge clk) begin
    if (want !== in_pins) begin
      in_pins <= want;
      since_chg <= 0;
    end else begin
      since_chg <= since_chg + 1;
    end
  end
endmodule

//--- tb/tb_top.sv
// Self-checking bench of the scan-cycle controller
`timescale 1ns/1ns
`include "plcs_defines.svh"
module tb_top;
  localparam int TICK = 20;
  localparam int SCAN = 118; // Refresh, 101 steps, 16 end cycles
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [12:0] adr = 13'h0000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] dat_o;
  logic        ack;
  logic [11:0] want = 12'h000;
  logic [11:0] in_pins;
  logic [6:0]  out_pins;
  logic [31:0] rd;
  logic [15:0] prog [8] = '{16'h1005, 16'h7401, 16'h1401, 16'h3001,
                            16'h7402, 16'h2000, 16'h7403, 16'h7800};
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          k;
  int          t;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, design and terminal model
  always #25 clk = ~clk;
  plcs_ctrl #(.TICK_CYC(TICK)) u_dut (
    .clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .in_pins(in_pins), .out_pins(out_pins));
  plcs_term_model u_term (.clk(clk), .want(want), .in_pins(in_pins), .since_chg());

  ////////////////////////////////////////////////////////////////////////////
  // Compare, bus cycle, expectation and verdict
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [12:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    chk("wb_ack", {31'h0000_0000, ack}, 32'h0000_0001);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // Outputs of the test program: Y1 = X5, Y2 = Y1 and X1, Y3 = not X0
  function automatic logic [31:0] exp_y(input logic [11:0] x);
    exp_y = {25'h000_0000, 3'b000, ~x[0], x[5] & x[1], x[5], 1'b0};
  endfunction
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well above the expected run
  initial begin
    #3_000_000;
    n_mismatch++;
    $display("watchdog expired");
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    k = $urandom(32'h285f);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("out_pins", {25'h000_0000, out_pins}, 32'h0000_0000);
    for (k = 0; k < 3; k++) begin
      wb(1'b0, `PLCS_ADR_SCAN_MIN + 13'(4 * k), 32'h0000_0000);
      chk("scan_time", rd, 32'h0000_0000);
    end
    wb(1'b0, `PLCS_ADR_CTRL, 32'h0000_0000);
    chk("ctrl", rd, 32'h0000_0000);
    wb(1'b0, 13'h0020, 32'h0000_0000);
    chk("unmapped", rd, 32'h0000_0000);
    want <= 12'hA5C;
    repeat (8) @(posedge clk);
    wb(1'b0, `PLCS_ADR_X_IMG, 32'h0000_0000);
    chk("x_img_stopped", rd, 32'h0000_0A5C);
    wb(1'b0, `PLCS_ADR_TMR_BASE + 13'h003C, 32'h0000_0000);
    chk("timer15_clear", rd, 32'h0000_0000);
    $display("test reset_and_idle done");
    // Load program with END at step 100, then run
    for (k = 0; k <= 100; k++) begin
      wb(1'b1, `PLCS_ADR_PROG_BASE + 13'(4 * k),
         (k < 8) ? {16'h0000, prog[k]} : (k == 100) ? 32'h0000_F000 : 32'h0000_0000);
    end
    wb(1'b1, `PLCS_ADR_CTRL, 32'h0000_0001);
    // Random inputs: settled outputs, images and timer coil
    for (k = 0; k < 8; k++) begin
      want <= (k == 0) ? 12'h022 : 12'($urandom());
      repeat (2 * SCAN + 8) @(posedge clk);
      chk("out_pins", {25'h000_0000, out_pins}, exp_y(want));
      wb(1'b0, `PLCS_ADR_Y_IMG, 32'h0000_0000);
      chk("y_img", rd, exp_y(want));
      wb(1'b0, `PLCS_ADR_X_IMG, 32'h0000_0000);
      chk("x_img", rd, {20'h0_0000, want});
      wb(1'b0, `PLCS_ADR_TMR_BASE, 32'h0000_0000);
      chk("timer0_active", {31'h0000_0000, rd != 0}, {31'h0000_0000, ~want[0]});
    end
    $display("test random_inputs done");
    // Input to output latency on X5 at random phases
    for (k = 0; k < 6; k++) begin
      repeat ($urandom_range(SCAN, 0)) @(posedge clk);
      want <= want ^ 12'h020;
      @(posedge clk);
      t = 0;
      while (out_pins[1] !== want[5] && t < 3 * SCAN) begin
        @(posedge clk);
        t++;
      end
      chk("latency_in_range", {31'h0, t >= SCAN && t <= 2 * SCAN + 8}, 32'h0000_0001);
    end
    $display("test latency done");
    // Scan time registers: 118 cycles at 20 cycles a unit
    wb(1'b0, `PLCS_ADR_SCAN_PRES, 32'h0000_0000);
    t = int'(rd);
    chk("scan_present", {31'h0, t == 5 || t == 6}, 32'h0000_0001);
    wb(1'b0, `PLCS_ADR_SCAN_MIN, 32'h0000_0000);
    chk("scan_min", {31'h0, rd >= 5 && rd <= t}, 32'h0000_0001);
    wb(1'b0, `PLCS_ADR_SCAN_MAX, 32'h0000_0000);
    chk("scan_max", {31'h0, rd <= 6 && rd >= t}, 32'h0000_0001);
    $display("test scan_time done");
    // Stop: outputs off, image kept, refresh continues
    wb(1'b1, `PLCS_ADR_CTRL, 32'h0000_0000);
    @(posedge clk);
    chk("out_pins_stop", {25'h000_0000, out_pins}, 32'h0000_0000);
    wb(1'b0, `PLCS_ADR_STATUS, 32'h0000_0000);
    chk("running", {31'h0, rd[`PLCS_STAT_RUNNING]}, 32'h0000_0000);
    wb(1'b0, `PLCS_ADR_Y_IMG, 32'h0000_0000);
    chk("y_img_kept", rd, exp_y(want));
    want <= ~want;
    repeat (2 * SCAN) @(posedge clk);
    chk("out_pins_stop", {25'h000_0000, out_pins}, 32'h0000_0000);
    wb(1'b0, `PLCS_ADR_X_IMG, 32'h0000_0000);
    chk("x_img_stopped", rd, {20'h0_0000, want});
    wb(1'b1, `PLCS_ADR_CTRL, 32'h0000_0001);
    repeat (2 * SCAN + 8) @(posedge clk);
    chk("out_pins_rerun", {25'h000_0000, out_pins}, exp_y(want));
    $display("test stop_restart done");
    // Clock enable low freezes outputs even when inputs move
    rd = exp_y(want);
    ce <= 1'b0;
    want <= ~want;
    repeat (2 * SCAN + 8) @(posedge clk);
    chk("out_pins_frozen", {25'h000_0000, out_pins}, rd);
    ce <= 1'b1;
    @(posedge clk);
    $display("test clock_enable done");
    tally_and_finish();
  end
endmodule
